// File: hjr_regs.sv
`timescale 1ns/1ps
`include "hjr_consts.svh"
module hjr_regs #(
  parameter int GW = 6,
  parameter int POLL_FAST_CYC = `HJR_POLL_FAST_MS * `HJR_CLK_KHZ,
  parameter int POLL_SLOW_CYC = `HJR_POLL_SLOW_MS * `HJR_CLK_KHZ,
  parameter int SLEW_STEP_CYC = `HJR_SLEW_STEP_US * `HJR_CLK_KHZ / 1000,
  parameter logic [6:0] DEV_ADDR = `HJR_DEV_ADDR
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic power_down_control,
  input wire logic sleep_ctrl,
  input wire logic switch_broken,
  input wire logic jack_switch_contact,
  input wire logic det_done,
  input wire logic det_left,
  input wire logic det_right,
  input wire logic [GW-1:0] vol_target,
  output logic left_channel_enable,
  output logic right_channel_enable,
  output logic [GW-1:0] hp_gain,
  output logic supply_threshold_select,
  output logic jack_poll,
  output logic jack_event,
  output logic det_start,
  output logic low_power,
  output logic en1_read_only,
  output logic clock_set_unlocked
);
  hjr_pkg::hjr_en2_s en2_q;
  hjr_pkg::hjr_wr_s wr;
  logic [7:0] clkflex_q;
  logic [7:0] rd_addr;
  logic [7:0] rd_data;
  logic [1:0] jack_s_q;
  logic jack_p_q;
  logic pdc_p_q;
  logic [31:0] poll_cnt_q;
  logic [31:0] poll_lim;
  logic auto_mode;
  logic want_l;
  logic want_r;
  logic ramp_busy;
  logic [GW-1:0] gain;
  logic left_q;
  logic right_q;

  // every count must be at least one cycle
  if (POLL_FAST_CYC < 1 || POLL_SLOW_CYC < 1 || SLEW_STEP_CYC < 1 || GW < 1) begin : g_chk
    $error("hjr_regs: bad parameters");
  end

  // true when an address hits the given register
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // serial control port
  hjr_i2c_port #(
    .DEV_ADDR(DEV_ADDR)
  ) u_port (
    .clk(clk),
    .rst_b(rst_b),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .wr(wr),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // both automatic encodings lock the enable bits; 11 is treated like them
  assign auto_mode = (en2_q.mode != hjr_pkg::hjr_manual);

  // what the device chooses in automatic mode
  always_comb begin
    want_l = 1'b0;
    want_r = 1'b0;
    case (en2_q.mode)
      hjr_pkg::hjr_auto_gated: begin
        if (!sleep_ctrl && power_down_control && det_done) begin
          want_l = det_left;
          want_r = det_right;
        end
      end
      hjr_pkg::hjr_auto_free: begin
        if (det_done) begin
          want_l = det_left;
          want_r = det_right;
        end
      end
      hjr_pkg::hjr_invalid: begin
        want_l = en2_q.left; // undefined encoding: hold what is there
        want_r = en2_q.right;
      end
      default: begin
        want_l = en2_q.left;
        want_r = en2_q.right;
      end
    endcase
  end

  // channel enables: host bits in manual, device status in the two automatic modes, held in 11
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en2_q.left <= 1'b0;
      en2_q.right <= 1'b0;
    end else if (auto_mode) begin
      en2_q.left <= want_l;
      en2_q.right <= want_r;
    end else if (wr.wr && hit(wr.addr, `HJR_ADDR_EN2)) begin
      en2_q.left <= wr.wdata[7];
      en2_q.right <= wr.wdata[6];
    end
  end

  // the other fields of the second enable register stay writable in every mode
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en2_q.slew_dis <= 1'b0;
      en2_q.perf <= 1'b0;
      en2_q.fast <= 1'b0;
      en2_q.thr <= 1'b0;
      en2_q.mode <= hjr_pkg::hjr_mode_e'(2'(`HJR_EN2_RESET));
    end else if (wr.wr && hit(wr.addr, `HJR_ADDR_EN2)) begin
      en2_q.slew_dis <= wr.wdata[5];
      en2_q.perf <= wr.wdata[4];
      en2_q.fast <= wr.wdata[3];
      en2_q.thr <= wr.wdata[2];
      en2_q.mode <= hjr_pkg::hjr_mode_e'(wr.wdata[1:0]);
    end
  end

  // clock unlock register; a plain store, the key is judged downstream
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clkflex_q <= `HJR_CLKFLEX_RESET;
    end else if (wr.wr && hit(wr.addr, `HJR_ADDR_CLKFLEX)) begin
      clkflex_q <= wr.wdata;
    end
  end

  assign clock_set_unlocked = (clkflex_q == `HJR_CLKFLEX_KEY);

  // read mux; unmapped addresses answer zero since the serial port has no error reply
  always_comb begin
    if (hit(rd_addr, `HJR_ADDR_EN2)) begin
      rd_data = en2_q;
    end else if (hit(rd_addr, `HJR_ADDR_RSVD)) begin
      rd_data = `HJR_RSVD_VALUE;
    end else if (hit(rd_addr, `HJR_ADDR_CLKFLEX)) begin
      rd_data = clkflex_q;
    end else begin
      rd_data = `HJR_READ_NONE;
    end
  end

  // the first enable register lives elsewhere; tell it when it is locked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      en1_read_only <= 1'b0;
    end else begin
      en1_read_only <= auto_mode;
    end
  end

  // low power only in the gated automatic mode with shutdown held low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      low_power <= 1'b0;
    end else begin
      low_power <= (en2_q.mode == hjr_pkg::hjr_auto_gated) && !power_down_control;
    end
  end

  // detection kicks off on the rising edge of the shutdown control
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pdc_p_q <= 1'b0;
      det_start <= 1'b0;
    end else begin
      pdc_p_q <= power_down_control;
      det_start <= power_down_control & ~pdc_p_q;
    end
  end

  // jack switch is a pin: two flops, then an edge detector on the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jack_s_q <= 2'h0;
      jack_p_q <= 1'b0;
    end else begin
      jack_s_q <= {jack_s_q[0], jack_switch_contact};
      jack_p_q <= jack_s_q[1];
    end
  end

  // a working switch reports insertion or removal at once
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jack_event <= 1'b0;
    end else begin
      jack_event <= !switch_broken && (jack_s_q[1] != jack_p_q);
    end
  end

  // polling interval follows the speed bit
  assign poll_lim = en2_q.fast ? 32'(POLL_FAST_CYC) : 32'(POLL_SLOW_CYC);

  // periodic polls only while the switch is broken; >= copes with a speed
  // change that lands past the new, shorter limit
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      poll_cnt_q <= 32'h0;
      jack_poll <= 1'b0;
    end else if (!switch_broken) begin
      poll_cnt_q <= 32'h0;
      jack_poll <= 1'b0;
    end else if (poll_cnt_q >= poll_lim - 32'h1) begin
      poll_cnt_q <= 32'h0;
      jack_poll <= 1'b1;
    end else begin
      poll_cnt_q <= poll_cnt_q + 32'h1;
      jack_poll <= 1'b0;
    end
  end

  // volume ramp shared by both channels
  hjr_slew #(
    .GW(GW),
    .STEP_CYC(SLEW_STEP_CYC)
  ) u_slew (
    .clk(clk),
    .rst_b(rst_b),
    .on(en2_q.left | en2_q.right),
    .slew_dis(en2_q.slew_dis),
    .target(vol_target),
    .gain_q(gain),
    .busy(ramp_busy)
  );

  // once both bits are clear, a channel stays on until the ramp reaches minimum,
  // so turn-off is heard as a fade and not a click
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left_q <= 1'b0;
      right_q <= 1'b0;
    end else begin
      left_q <= en2_q.left | (left_q & ramp_busy);
      right_q <= en2_q.right | (right_q & ramp_busy);
    end
  end

  assign left_channel_enable = left_q;
  assign right_channel_enable = right_q;
  assign hp_gain = gain;

  // class-G threshold goes straight to the supply switch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      supply_threshold_select <= 1'b0;
    end else begin
      supply_threshold_select <= en2_q.thr;
    end
  end
endmodule : hjr_regs

// File: hjr_consts.svh
`ifndef HJR_CONSTS_SVH
`define HJR_CONSTS_SVH
`define HJR_ADDR_EN1 8'h1D
`define HJR_ADDR_EN2 8'h1E
`define HJR_ADDR_RSVD 8'h1F
`define HJR_ADDR_CLKFLEX 8'h66
`define HJR_EN2_RESET 8'h01
`define HJR_RSVD_VALUE 8'h00
`define HJR_CLKFLEX_RESET 8'h00
`define HJR_CLKFLEX_KEY 8'hF1
`define HJR_READ_NONE 8'h00
`define HJR_CLK_KHZ 20000
`define HJR_POLL_FAST_MS 333
`define HJR_POLL_SLOW_MS 2000
`define HJR_SLEW_STEP_US 1000
`define HJR_I2C_ACK_BIT 4'h8
`define HJR_I2C_LAST_BIT 4'h7
`define HJR_I2C_START_CNT 4'hF
`define HJR_DEV_ADDR 7'h40
`endif

// File: hjr_pkg.sv
package hjr_pkg;
  // automatic-mode selector encodings
  typedef enum logic [1:0] {
    hjr_manual = 2'b00,
    hjr_auto_gated = 2'b01,
    hjr_auto_free = 2'b10,
    hjr_invalid = 2'b11
  } hjr_mode_e;
  // field layout of the second enable register, msb first
  typedef struct packed {
    logic left;
    logic right;
    logic slew_dis;
    logic perf;
    logic fast;
    logic thr;
    hjr_mode_e mode;
  } hjr_en2_s;
  // one register write from the serial port
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } hjr_wr_s;
  // serial port byte phases
  typedef enum logic [2:0] {
    hjr_idle = 3'b000,
    hjr_dev = 3'b001,
    hjr_ptr = 3'b010,
    hjr_wdat = 3'b011,
    hjr_rdat = 3'b100
  } hjr_i2c_e;
endpackage : hjr_pkg

// File: hjr_i2c_port.sv
`timescale 1ns/1ps
`include "hjr_consts.svh"
module hjr_i2c_port #(
  parameter logic [6:0] DEV_ADDR = `HJR_DEV_ADDR
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output hjr_pkg::hjr_wr_s wr,
  output logic [7:0] rd_addr,
  input wire logic [7:0] rd_data
);
  logic [1:0] scl_s_q;
  logic [1:0] sda_s_q;
  logic scl_p_q;
  logic sda_p_q;
  hjr_pkg::hjr_i2c_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] sr_q;
  logic [7:0] ptr_q;
  logic [7:0] tx_q;
  logic ack_q;
  logic rise;
  logic fall;
  logic start;
  logic stop;

  // pins pass two flops; edges are judged on the second stage only
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end

  assign rise = scl_s_q[1] & ~scl_p_q;
  assign fall = ~scl_s_q[1] & scl_p_q;
  assign start = scl_s_q[1] & scl_p_q & sda_p_q & ~sda_s_q[1];
  assign stop = scl_s_q[1] & scl_p_q & ~sda_p_q & sda_s_q[1];

  // byte engine: device address, register pointer, then data with auto-increment
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= hjr_pkg::hjr_idle;
      cnt_q <= 4'h0;
      sr_q <= 8'h00;
      ptr_q <= 8'h00;
      tx_q <= 8'h00;
      ack_q <= 1'b0;
      wr <= '0;
    end else begin
      wr.wr <= 1'b0;
      if (start) begin
        st_q <= hjr_pkg::hjr_dev;
        // the scl fall that closes the start is not a data bit; it wraps the count to zero
        cnt_q <= `HJR_I2C_START_CNT;
        ack_q <= 1'b0;
      end else if (stop) begin
        st_q <= hjr_pkg::hjr_idle;
        ack_q <= 1'b0;
      end else if (rise && st_q != hjr_pkg::hjr_idle) begin
        if (cnt_q < `HJR_I2C_ACK_BIT) begin
          sr_q <= {sr_q[6:0], sda_s_q[1]};
        end else if (st_q == hjr_pkg::hjr_rdat && sda_s_q[1]) begin
          st_q <= hjr_pkg::hjr_idle; // master nack ends the read
        end
      end else if (fall && st_q != hjr_pkg::hjr_idle) begin
        if (cnt_q == `HJR_I2C_LAST_BIT) begin
          cnt_q <= `HJR_I2C_ACK_BIT;
          case (st_q)
            hjr_pkg::hjr_dev: ack_q <= (sr_q[7:1] == DEV_ADDR);
            hjr_pkg::hjr_ptr: begin
              ack_q <= 1'b1;
              ptr_q <= sr_q;
            end
            hjr_pkg::hjr_wdat: begin
              ack_q <= 1'b1;
              wr.wr <= 1'b1;
              wr.addr <= ptr_q;
              wr.wdata <= sr_q;
              ptr_q <= ptr_q + 8'h01;
            end
            default: ack_q <= 1'b0;
          endcase
        end else if (cnt_q == `HJR_I2C_ACK_BIT) begin
          cnt_q <= 4'h0;
          ack_q <= 1'b0;
          case (st_q)
            hjr_pkg::hjr_dev: begin
              if (!ack_q) begin
                st_q <= hjr_pkg::hjr_idle;
              end else if (sr_q[0]) begin
                st_q <= hjr_pkg::hjr_rdat;
                tx_q <= rd_data;
                ptr_q <= ptr_q + 8'h01;
              end else begin
                st_q <= hjr_pkg::hjr_ptr;
              end
            end
            hjr_pkg::hjr_ptr: st_q <= hjr_pkg::hjr_wdat;
            hjr_pkg::hjr_rdat: begin
              tx_q <= rd_data;
              ptr_q <= ptr_q + 8'h01;
            end
            default: st_q <= st_q;
          endcase
        end else begin
          cnt_q <= cnt_q + 4'h1;
          if (st_q == hjr_pkg::hjr_rdat) begin
            tx_q <= {tx_q[6:0], 1'b0};
          end
        end
      end
    end
  end

  // open drain: only ever pull low
  assign sda_o = 1'b0;
  assign sda_oe = ack_q | (st_q == hjr_pkg::hjr_rdat && cnt_q < `HJR_I2C_ACK_BIT && !tx_q[7]);
  assign rd_addr = ptr_q;
endmodule : hjr_i2c_port

// File: hjr_slew.sv
`timescale 1ns/1ps
module hjr_slew #(
  parameter int GW = 6,
  parameter int STEP_CYC = 20000
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic on,
  input wire logic slew_dis,
  input wire logic [GW-1:0] target,
  output logic [GW-1:0] gain_q,
  output logic busy
);
  logic [31:0] tick_q;
  logic [GW-1:0] goal;
  logic step;

  if (STEP_CYC < 1 || GW < 1) begin : g_chk
    $error("hjr_slew: bad parameters");
  end

  // off means the minimum setting
  assign goal = on ? target : '0;
  assign step = (tick_q == 32'(STEP_CYC - 1));
  assign busy = (gain_q != goal);

  // free-running step timer paces each gain step
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_q <= 32'h0;
    end else if (step) begin
      tick_q <= 32'h0;
    end else begin
      tick_q <= tick_q + 32'h1;
    end
  end

  // one step per tick through every intermediate value, or jump when disabled
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gain_q <= '0;
    end else if (slew_dis) begin
      gain_q <= goal;
    end else if (step && gain_q < goal) begin
      gain_q <= gain_q + GW'(1);
    end else if (step && gain_q > goal) begin
      gain_q <= gain_q - GW'(1);
    end
  end
endmodule : hjr_slew

// File: hjr_regs_props.sv
`timescale 1ns/1ps
module hjr_regs_props #(
  parameter int GW = 6,
  parameter int POLL_FAST_CYC = 30,
  parameter int POLL_SLOW_CYC = 60
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic scl_i,
  input wire logic sda_oe,
  input wire logic power_down_control,
  input wire logic switch_broken,
  input wire logic left_channel_enable,
  input wire logic right_channel_enable,
  input wire logic [GW-1:0] hp_gain,
  input wire logic jack_poll,
  input wire logic jack_event,
  input wire logic det_start,
  input wire logic low_power,
  input wire logic en1_read_only
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic [31:0] gap_q;
  logic armed_q;
  // cycles since the last poll; a working switch disarms, so a speed change made while the switch works never skews a gap
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      gap_q <= 32'h0;
      armed_q <= 1'h0;
    end else if (!switch_broken) begin
      gap_q <= 32'h0;
      armed_q <= 1'h0;
    end else if (jack_poll) begin
      gap_q <= 32'h1;
      armed_q <= 1'h1;
    end else begin
      gap_q <= gap_q + 32'h1;
    end
  end
  AST_DET_START:
    assert property ($rose(power_down_control) |=> det_start) else $error("no detection start after shutdown rise");
  AST_DET_PULSE:
    assert property (det_start |=> !det_start) else $error("detection start longer than one cycle");
  AST_POLL_BROKEN:
    assert property (jack_poll |-> $past(switch_broken)) else $error("poll while the jack switch works");
  AST_POLL_GAP:
    assert property (jack_poll && armed_q |-> gap_q == 32'(POLL_FAST_CYC) || gap_q == 32'(POLL_SLOW_CYC))
      else $error("poll interval is neither fast nor slow");
  AST_EVENT_WORKING:
    assert property (jack_event |-> !$past(switch_broken)) else $error("switch event while switch is broken");
  AST_LEFT_OFF_MIN:
    assert property ($fell(left_channel_enable) |-> $past(hp_gain) == {GW{1'b0}}) else $error("left off above min gain");
  AST_RIGHT_OFF_MIN:
    assert property ($fell(right_channel_enable) |-> $past(hp_gain) == {GW{1'b0}}) else $error("right off above min gain");
  AST_LOW_POWER:
    assert property (low_power |-> en1_read_only && !$past(power_down_control)) else $error("bad low power entry");
  AST_SDA_MOVE:
    assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i)) else $error("sda drive changed with scl high");
  AST_SDA_HOLD:
    assert property ($rose(scl_i) && sda_oe |-> sda_oe [*8]) else $error("sda drive dropped during scl high");
endmodule : hjr_regs_props

bind hjr_regs hjr_regs_props #(.GW(GW), .POLL_FAST_CYC(POLL_FAST_CYC), .POLL_SLOW_CYC(POLL_SLOW_CYC)) u_props (
  .clk(clk), .rst_b(rst_b), .scl_i(scl_i), .sda_oe(sda_oe), .power_down_control(power_down_control),
  .switch_broken(switch_broken), .left_channel_enable(left_channel_enable),
  .right_channel_enable(right_channel_enable), .hp_gain(hp_gain), .jack_poll(jack_poll),
  .jack_event(jack_event), .det_start(det_start), .low_power(low_power), .en1_read_only(en1_read_only));

// File: hjr_host_model.sv
`timescale 1ns/1ps
module hjr_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h40
) (
  input wire logic clk,
  input wire logic sda_oe,
  input wire logic sda_o,
  output logic scl,
  output logic sda
);
  logic pull_q;
  initial begin
    scl = 1'h1;
    pull_q = 1'h0;
  end
  // open drain with pull-up: any party pulling low wins, released line reads high
  assign sda = ~(pull_q | (sda_oe & ~sda_o));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  // 8 clocks low, 8 high: well above the 4 the device needs to sample
  task automatic bit_io(input logic b, output logic s);
    pull_q <= ~b;
    cyc(4);
    scl <= 1'h1;
    cyc(4);
    s = sda;
    cyc(4);
    scl <= 1'h0;
    cyc(4);
  endtask : bit_io
  task automatic send(input logic [7:0] d, output logic [7:0] q, output logic nack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(1'h1, nack);
  endtask : send
  // sda released before scl rises, so a repeated start is never taken for a stop
  task automatic start_c;
    cyc(1);
    pull_q <= 1'h0;
    cyc(4);
    scl <= 1'h1;
    cyc(8);
    pull_q <= 1'h1;
    cyc(8);
    scl <= 1'h0;
    cyc(4);
  endtask : start_c
  task automatic stop_c;
    pull_q <= 1'h1;
    cyc(4);
    scl <= 1'h1;
    cyc(8);
    pull_q <= 1'h0;
    cyc(8);
  endtask : stop_c
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic n;
    start_c;
    send({DEV_ADDR, 1'h0}, q, n);
    send(a, q, n);
    send(d, q, n);
    stop_c;
  endtask : write_reg
  // last byte answered with a nack, as a host must before its stop
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic n0, n1, n2, n3;
    start_c;
    send({DEV_ADDR, 1'h0}, q, n0);
    send(a, q, n1);
    start_c;
    send({DEV_ADDR, 1'h1}, q, n2);
    send(8'hFF, d, n3);
    stop_c;
    ok = ~(n0 | n1 | n2);
  endtask : read_reg
endmodule : hjr_host_model

// File: tb_headset_enable_control_regs.sv
`timescale 1ns/1ps
module tb_headset_enable_control_regs;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic thr;
    logic unl;
  } hjr_row_s;
  logic clk, rst_b, scl, sda, sda_o, sda_oe, pdc, sleep_c, broken, contact, det_done, det_l, det_r;
  logic left_en, right_en, thr, poll, jev, dstart, lowp, ro, unl;
  logic [5:0] vol, gain, gain_prev, delta, jump;
  logic [7:0] rv;
  int mismatches, cmp_count, n, np, ne;
  hjr_row_s rows [7] = '{'{8'h1E, 8'h10, 8'h10, 1'h0, 1'h0}, '{8'h1E, 8'h14, 8'h14, 1'h1, 1'h0},
    '{8'h1E, 8'h18, 8'h18, 1'h0, 1'h0}, '{8'h1F, 8'hFF, 8'h00, 1'h0, 1'h0}, '{8'h66, 8'hF1, 8'hF1, 1'h0, 1'h1},
    '{8'h66, 8'h00, 8'h00, 1'h0, 1'h0}, '{8'h50, 8'hAA, 8'h00, 1'h0, 1'h0}};
  hjr_regs #(.POLL_FAST_CYC(30), .POLL_SLOW_CYC(60), .SLEW_STEP_CYC(4)) uut (.clk(clk), .rst_b(rst_b),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .power_down_control(pdc), .sleep_ctrl(sleep_c),
    .switch_broken(broken), .jack_switch_contact(contact), .det_done(det_done), .det_left(det_l),
    .det_right(det_r), .vol_target(vol), .left_channel_enable(left_en), .right_channel_enable(right_en),
    .hp_gain(gain), .supply_threshold_select(thr), .jack_poll(poll), .jack_event(jev), .det_start(dstart),
    .low_power(lowp), .en1_read_only(ro), .clock_set_unlocked(unl));
  hjr_host_model host (.clk(clk), .sda_oe(sda_oe), .sda_o(sda_o), .scl(scl), .sda(sda));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // largest gain step seen since the bench last cleared it
  always @(posedge clk) begin
    gain_prev <= gain;
    delta = (gain > gain_prev) ? gain - gain_prev : gain_prev - gain;
    if (rst_b && delta > jump) jump = delta;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic ok;
    host.read_reg(a, rv, ok);
    check("read ack", 8'h01, {7'h00, ok});
    check("register", exp, rv);
  endtask : rd
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish
  // cycles from one poll pulse to the next, bounded so a dead poller cannot hang
  task automatic poll_gap(output int g);
    for (int i = 0; i < 300 && poll !== 1'h1; i++) @(posedge clk);
    @(posedge clk);
    g = 1;
    while (poll !== 1'h1 && g < 300) begin
      @(posedge clk);
      g++;
    end
  endtask : poll_gap
  initial begin
    repeat (80000) @(posedge clk);
    mismatches++;
    $display("MISMATCH watchdog expected done seen timeout");
    tally_and_finish;
  end
  initial begin
    {rst_b, pdc, sleep_c, broken, contact, det_done, det_l, det_r, jump} = '0;
    vol = 6'h05;
    repeat (6) @(posedge clk);
    check("reset outs", 8'h00, {left_en, right_en, thr, poll, dstart, lowp, ro, unl});
    rst_b <= 1'h1;
    repeat (3) @(posedge clk);
    rd(8'h1E, 8'h01);
    check("read only", 8'h01, {7'h00, ro});
    det_done <= 1'h1;
    det_l <= 1'h1;
    foreach (rows[i]) begin
      host.write_reg(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr, rows[i].rdata);
      check("threshold", {7'h00, rows[i].thr}, {7'h00, thr});
      check("unlock", {7'h00, rows[i].unl}, {7'h00, unl});
    end
    jump = 6'h00;
    host.write_reg(8'h1E, 8'hD0);
    for (int i = 0; i < 300 && gain !== 6'h05; i++) @(posedge clk);
    check("ramp up", 8'h01, {2'h0, jump});
    check("both on", 8'h03, {6'h00, left_en, right_en});
    host.write_reg(8'h1E, 8'h10);
    for (int i = 0; i < 300 && left_en !== 1'h0; i++) @(posedge clk);
    check("ramp down", 8'h01, {2'h0, jump});
    check("off gain", 8'h00, {gain[5:0], right_en, left_en});
    host.write_reg(8'h1E, 8'hF0);
    for (int i = 0; i < 300 && gain !== 6'h05; i++) @(posedge clk);
    check("no slew", 8'h05, {2'h0, jump});
    host.write_reg(8'h1E, 8'h30);
    sleep_c <= 1'h1;
    host.write_reg(8'h1E, 8'h12);
    for (int i = 0; i < 300 && left_en !== 1'h1; i++) @(posedge clk);
    check("auto free", 8'h02, {6'h00, left_en, right_en});
    host.write_reg(8'h1E, 8'h52);
    rd(8'h1E, 8'h92);
    host.write_reg(8'h1E, 8'h10);
    host.write_reg(8'h1E, 8'h11);
    for (int i = 0; i < 300 && left_en !== 1'h0; i++) @(posedge clk);
    rd(8'h1E, 8'h11);
    check("low power", 8'h01, {7'h00, lowp});
    @(posedge clk);
    pdc <= 1'h1;
    sleep_c <= 1'h0;
    @(posedge clk);
    #1 check("det start", 8'h01, {7'h00, dstart});
    for (int i = 0; i < 300 && left_en !== 1'h1; i++) @(posedge clk);
    rd(8'h1E, 8'h91);
    check("awake", 8'h00, {7'h00, lowp});
    host.write_reg(8'h1E, 8'h18);
    broken <= 1'h1;
    poll_gap(n);
    check("fast gap", 8'(30), n[7:0]);
    broken <= 1'h0;
    host.write_reg(8'h1E, 8'h10);
    broken <= 1'h1;
    poll_gap(n);
    check("slow gap", 8'(60), n[7:0]);
    broken <= 1'h0;
    contact <= 1'h1;
    repeat (200) begin
      @(posedge clk);
      np += int'(poll === 1'h1);
      ne += int'(jev === 1'h1);
    end
    check("switch polls", 8'h00, np[7:0]);
    check("switch events", 8'h01, ne[7:0]);
    tally_and_finish;
  end
endmodule : tb_headset_enable_control_regs
